/* rtl/spp_pkg.sv */
// Shared constants for the framed serial port: register map, field positions, engine states.
// Assumes a 16-bit register view placed in the low half of a 32-bit APB word.
package spp_pkg;
    localparam logic [7:0]  ADDR_STAT    = 8'h00;
    localparam logic [7:0]  ADDR_CON1    = 8'h04;
    localparam logic [7:0]  ADDR_CON2    = 8'h08;
    localparam logic [7:0]  ADDR_BUF     = 8'h0C;

    localparam int          STAT_EN      = 15;
    localparam int          STAT_SIDL    = 13;
    localparam int          STAT_ROV     = 6;
    localparam int          STAT_TBF     = 1;
    localparam int          STAT_RBF     = 0;

    localparam int          CON1_CLOCK_PIN_DISABLE  = 12;
    localparam int          CON1_DATA_OUT_DISABLE  = 11;
    localparam int          CON1_WORD_WIDTH_SELECT  = 10;
    localparam int          CON1_SMP     = 9;
    localparam int          CON1_CKE     = 8;
    localparam int          CON1_SLAVE_SELECT_ENABLE    = 7;
    localparam int          CON1_CKP     = 6;
    localparam int          CON1_MASTER_ENABLE   = 5;
    localparam int          CON1_SPRE    = 2;
    localparam int          CON1_PPRE    = 0;

    localparam int          CON2_FRAMED_MODE_ENABLE   = 15;
    localparam int          CON2_FSD     = 14;
    localparam int          CON2_FRAME_SYNC_POLARITY  = 13;
    localparam int          CON2_FRAME_SYNC_EDGE  = 1;

    localparam logic [15:0] CON1_WMASK   = 16'h1FFF;
    localparam logic [15:0] CON2_WMASK   = 16'hE002;
    localparam logic [5:0]  BITS_WORD    = 6'h10;
    localparam logic [5:0]  BITS_BYTE    = 6'h08;
    localparam logic [5:0]  LEAD_HALVES  = 6'h02;
    localparam logic [5:0]  FRAME_HALVES = 6'h02;
    localparam logic [1:0]  PPRE_TOP     = 2'h3;
    localparam logic [3:0]  SPRE_SPAN    = 4'h8;
    localparam int          HALF_W       = 10;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_LEAD  = 3'b010,
        ST_SHIFT = 3'b100
    } spp_state_t;

    // Half bit period in pclk cycles from the two prescale fields
    function automatic logic [HALF_W-1:0] half_period(input logic [1:0] ppre, input logic [2:0] spre);
        logic [3:0] sec;
        logic [1:0] pexp;
        sec  = SPRE_SPAN - {1'b0, spre};
        pexp = PPRE_TOP - ppre;
        half_period = HALF_W'({6'h00, sec} << {pexp, 1'b0});
    endfunction

    // Most significant bit for the selected word width
    function automatic logic msb_of(input logic [15:0] w, input logic wide);
        msb_of = wide ? w[15] : w[7];
    endfunction
endpackage

/* rtl/spp_tick_if.sv */
// Tick handshake between the serial engine and its bit-rate divider.
// Assumes both ends run on the same pclk.
`timescale 1ns/10ps
interface spp_tick_if;
    logic       run;
    logic [1:0] ppre;
    logic [2:0] spre;
    logic       tick;
    modport gen (input run, input ppre, input spre, output tick);
    modport eng (output run, output ppre, output spre, input tick);
endinterface

/* rtl/spp_baud.sv */
// Bit-rate divider: one-cycle tick every half bit period while run is high.
// Assumes run, ppre and spre come from pclk-domain logic.
`timescale 1ns/10ps
module spp_baud (
    input  wire logic pclk,
    input  wire logic presetn,
    spp_tick_if.gen   tk
);
    typedef struct packed {
        logic [spp_pkg::HALF_W-1:0] cnt;
        logic                       tick;
    } spp_baud_st_t;

    spp_baud_st_t               s;
    spp_baud_st_t               next_s;
    logic [spp_pkg::HALF_W-1:0] half;

    // Both ratios at 1:1 give a one-cycle half period
    assign half = spp_pkg::half_period(tk.ppre, tk.spre);

    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        if (!tk.run) begin
            next_s.cnt = '0;
        end else if (s.cnt == half - 10'h001) begin
            next_s.cnt  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 10'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tk.tick = s.tick;
endmodule

/* rtl/spp_port.sv */
// Framed serial port: APB register slave, 16-bit shift engine, master and slave timing.
// Assumes pclk at 25 MHz; link pins are asynchronous and pass three flip-flops.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/10ps
//Function
// - Words move through a 16-bit shift register between transmit and receive halves.
// - Four link pins: data in, data out, shift clock, active-low select.
// - Port enable bit 15 of status takes the pins; zero disables the port.
// - Idle-stop bit 13 halts the port while the processor is idle.
// - Word completing while receive half unread is dropped; overflow bit 6 set.
// - Transmit-full bit 1 sets on buffer write, clears on move to shifter.
// - Receive-full bit 0 sets on move to receive half, clears on read.
// - Clock disable bit 12 stops master clock and releases the clock pin.
// - Data-out disable bit 11 releases the data output pin.
// - Width select: one gives 16-bit words, zero gives 8-bit words.
// - Master samples at end of bit when phase bit set, else middle.
// - Clock-edge bit: data changes active-to-idle when one, idle-to-active when zero; framed mode here always changes idle-to-active.
// - Clock polarity bit 6: one means idle high, zero means idle low.
// - Slave-select enable bit 7 makes a slave honour the select pin.
// - Master-enable bit 5 selects master when one, slave when zero.
// - Framed-mode bit 15 turns the select pin into a frame sync pulse.
// - Frame sync direction bit 14: one input, zero output.
// - Frame sync polarity bit 13: one active high, zero active low.
// - Frame sync edge bit 1: one coincides with first bit, zero precedes it; applied to an output sync only, an input sync starts the word on its edge.
module spp_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_idle,
    input  wire logic        sdi_i,
    output logic             sdo_o,
    output logic             sdo_oe,
    input  wire logic        sck_i,
    output logic             sck_o,
    output logic             sck_oe,
    input  wire logic        ss_i,
    output logic             ss_o,
    output logic             ss_oe
);
    typedef struct packed {
        logic                en;
        logic                sidl;
        logic                rov;
        logic                tbf;
        logic                rbf;
        logic [15:0]         con1;
        logic [15:0]         con2;
        logic [15:0]         tx_half;
        logic [15:0]         rx_half;
        logic [15:0]         sr;
        spp_pkg::spp_state_t state;
        logic [5:0]          halfc;
        logic [4:0]          nsamp;
        logic                sck;
        logic                sdo;
        logic                ss_out;
        logic                sck_oe;
        logic                sdo_oe;
        logic                ss_oe;
        logic [2:0]          sdi_q;
        logic [2:0]          sck_q;
        logic [2:0]          ss_q;
        logic                sdi_f;
        logic                sck_f;
        logic                ss_f;
        logic                sck_prev;
        logic                fs_prev;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } spp_port_st_t;

    spp_port_st_t s;
    spp_port_st_t next_s;
    logic         run;
    logic         load;
    logic         word_done;
    logic         buf_wr;
    logic         buf_rd;

    spp_tick_if tk ();

    spp_baud u_baud (
        .pclk    (pclk),
        .presetn (presetn),
        .tk      (tk)
    );

    assign tk.ppre = s.con1[spp_pkg::CON1_PPRE +: 2];
    assign tk.spre = s.con1[spp_pkg::CON1_SPRE +: 3];
    assign tk.run  = run && s.con1[spp_pkg::CON1_MASTER_ENABLE] && !s.con1[spp_pkg::CON1_CLOCK_PIN_DISABLE]
                     && (s.state != spp_pkg::ST_IDLE);

    always_comb begin
        logic        acc;
        logic        wr_done;
        logic        rd_done;
        logic        master;
        logic        wide;
        logic        clock_polarity;
        logic        cke_eff;
        logic        slave_select_enable_eff;
        logic        framed_mode_enable;
        logic        fs_out_mode;
        logic        fs_act;
        logic        fs_edge;
        logic        sel;
        logic        lead_e;
        logic        trail_e;
        logic        sample;
        logic        change;
        logic [5:0]  bits;
        logic [5:0]  h;
        logic [15:0] sr_s;
        logic [15:0] rd;
        acc         = psel && penable;
        wr_done     = acc && s.pready && pwrite;
        rd_done     = acc && s.pready && !pwrite;
        master      = s.con1[spp_pkg::CON1_MASTER_ENABLE];
        wide        = s.con1[spp_pkg::CON1_WORD_WIDTH_SELECT];
        bits        = wide ? spp_pkg::BITS_WORD : spp_pkg::BITS_BYTE;
        clock_polarity         = s.con1[spp_pkg::CON1_CKP];
        framed_mode_enable       = s.con2[spp_pkg::CON2_FRAMED_MODE_ENABLE];
        fs_out_mode = framed_mode_enable && !s.con2[spp_pkg::CON2_FSD];
        cke_eff     = s.con1[spp_pkg::CON1_CKE] && !framed_mode_enable;
        slave_select_enable_eff    = s.con1[spp_pkg::CON1_SLAVE_SELECT_ENABLE] && !framed_mode_enable;
        fs_act      = (s.ss_f == s.con2[spp_pkg::CON2_FRAME_SYNC_POLARITY]);
        fs_edge     = fs_act && !s.fs_prev;
        sel         = framed_mode_enable ? fs_edge : (!slave_select_enable_eff || !s.ss_f);
        lead_e      = (s.sck_f != s.sck_prev) && (s.sck_f != clock_polarity);
        trail_e     = (s.sck_f != s.sck_prev) && (s.sck_f == clock_polarity);
        sample      = 1'b0;
        change      = 1'b0;
        h           = s.halfc + 6'h01;
        sr_s        = s.sr;
        rd          = 16'h0000;
        run         = s.en && !(s.sidl && cpu_idle);
        load        = 1'b0;
        word_done   = 1'b0;
        buf_wr      = wr_done && (paddr == spp_pkg::ADDR_BUF);
        buf_rd      = rd_done && (paddr == spp_pkg::ADDR_BUF);
        next_s      = s;

        // Pin synchronisers: a change counts once stages two and three agree
        next_s.sdi_q = {s.sdi_q[1:0], sdi_i};
        next_s.sck_q = {s.sck_q[1:0], sck_i};
        next_s.ss_q  = {s.ss_q[1:0], ss_i};
        if (s.sdi_q[1] == s.sdi_q[2]) begin
            next_s.sdi_f = s.sdi_q[2];
        end
        if (s.sck_q[1] == s.sck_q[2]) begin
            next_s.sck_f = s.sck_q[2];
        end
        if (s.ss_q[1] == s.ss_q[2]) begin
            next_s.ss_f = s.ss_q[2];
        end
        next_s.sck_prev = s.sck_f;
        next_s.fs_prev  = fs_act;

        // APB: access phase answered one cycle after it opens
        next_s.pready = acc && !s.pready;
        if (acc && !s.pready) begin
            next_s.pslverr = 1'b0;
            case (paddr)
                spp_pkg::ADDR_STAT: begin
                    rd[spp_pkg::STAT_EN]   = s.en;
                    rd[spp_pkg::STAT_SIDL] = s.sidl;
                    rd[spp_pkg::STAT_ROV]  = s.rov;
                    rd[spp_pkg::STAT_TBF]  = s.tbf;
                    rd[spp_pkg::STAT_RBF]  = s.rbf;
                end
                spp_pkg::ADDR_CON1: rd = s.con1;
                spp_pkg::ADDR_CON2: rd = s.con2;
                spp_pkg::ADDR_BUF:  rd = s.rx_half;
                default:            next_s.pslverr = 1'b1;
            endcase
            next_s.prdata = {16'h0000, rd};
        end
        if (wr_done) begin
            case (paddr)
                spp_pkg::ADDR_STAT: begin
                    next_s.en   = pwdata[spp_pkg::STAT_EN];
                    next_s.sidl = pwdata[spp_pkg::STAT_SIDL];
                    if (!pwdata[spp_pkg::STAT_ROV]) begin
                        next_s.rov = 1'b0;
                    end
                end
                spp_pkg::ADDR_CON1: next_s.con1 = pwdata[15:0] & spp_pkg::CON1_WMASK;
                spp_pkg::ADDR_CON2: next_s.con2 = pwdata[15:0] & spp_pkg::CON2_WMASK;
                default:            next_s.con1 = s.con1;
            endcase
        end
        if (buf_rd) begin
            next_s.rbf = 1'b0;
        end

        // Shift engine
        if (!s.en) begin
            next_s.state  = spp_pkg::ST_IDLE;
            next_s.tbf    = 1'b0;
            next_s.rbf    = 1'b0;
            next_s.rov    = 1'b0;
            next_s.halfc  = 6'h00;
            next_s.nsamp  = 5'h00;
            next_s.sck    = clock_polarity;
            next_s.ss_out = !s.con2[spp_pkg::CON2_FRAME_SYNC_POLARITY];
        end else if (run) begin
            unique case (s.state)
                spp_pkg::ST_IDLE: begin
                    next_s.halfc = 6'h00;
                    next_s.nsamp = 5'h00;
                    next_s.sck   = clock_polarity;
                    if (master && !s.con1[spp_pkg::CON1_CLOCK_PIN_DISABLE] && s.tbf
                        && (!framed_mode_enable || fs_out_mode || fs_edge)) begin
                        load         = 1'b1;
                        next_s.state = spp_pkg::ST_SHIFT;
                        next_s.sck   = clock_polarity ^ !cke_eff;
                        if (fs_out_mode) begin
                            next_s.ss_out = s.con2[spp_pkg::CON2_FRAME_SYNC_POLARITY];
                            if (!s.con2[spp_pkg::CON2_FRAME_SYNC_EDGE]) begin
                                next_s.state = spp_pkg::ST_LEAD;
                                next_s.sck   = clock_polarity;
                            end
                        end
                    end else if (!master && sel) begin
                        load         = s.tbf;
                        next_s.state = spp_pkg::ST_SHIFT;
                    end
                end
                spp_pkg::ST_LEAD: begin
                    if (tk.tick) begin
                        next_s.halfc = h;
                        if (h == spp_pkg::LEAD_HALVES) begin
                            next_s.halfc  = 6'h00;
                            next_s.ss_out = !s.con2[spp_pkg::CON2_FRAME_SYNC_POLARITY];
                            next_s.state  = spp_pkg::ST_SHIFT;
                            next_s.sck    = clock_polarity ^ !cke_eff;
                        end
                    end
                end
                spp_pkg::ST_SHIFT: begin
                    if (master) begin
                        if (tk.tick) begin
                            next_s.halfc = h;
                            if (h[0]) begin
                                next_s.sck = clock_polarity ^ cke_eff;
                                sample     = !s.con1[spp_pkg::CON1_SMP];
                            end else begin
                                sample     = s.con1[spp_pkg::CON1_SMP];
                                change     = (h != {bits[4:0], 1'b0});
                                next_s.sck = clock_polarity ^ (!cke_eff && change);
                            end
                            if (fs_out_mode && s.con2[spp_pkg::CON2_FRAME_SYNC_EDGE] && h == spp_pkg::FRAME_HALVES) begin
                                next_s.ss_out = !s.con2[spp_pkg::CON2_FRAME_SYNC_POLARITY];
                            end
                            word_done = (h == {bits[4:0], 1'b0});
                        end
                    end else if (slave_select_enable_eff && s.ss_f) begin
                        next_s.state = spp_pkg::ST_IDLE;
                        next_s.nsamp = 5'h00;
                    end else begin
                        sample    = cke_eff ? lead_e : trail_e;
                        change    = cke_eff ? trail_e : lead_e;
                        word_done = sample && (s.nsamp + 5'h01 == bits[4:0]);
                        load      = s.tbf && (word_done || (s.nsamp == 5'h00 && !sample));
                    end
                end
                default: next_s.state = spp_pkg::ST_IDLE;
            endcase
        end

        if (sample) begin
            sr_s         = {s.sr[14:0], s.sdi_f};
            next_s.sr    = sr_s;
            next_s.nsamp = s.nsamp + 5'h01;
        end
        if (change) begin
            next_s.sdo = spp_pkg::msb_of(sr_s, wide);
        end
        if (word_done) begin
            next_s.nsamp = 5'h00;
            if (master || framed_mode_enable) begin
                next_s.state = spp_pkg::ST_IDLE;
            end
            if (s.rbf && !buf_rd) begin
                next_s.rov = 1'b1;
            end else begin
                next_s.rx_half = wide ? sr_s : {8'h00, sr_s[7:0]};
                next_s.rbf     = 1'b1;
            end
        end
        if (load) begin
            next_s.sr  = s.tx_half;
            next_s.tbf = 1'b0;
            next_s.sdo = spp_pkg::msb_of(s.tx_half, wide);
        end
        if (buf_wr) begin
            next_s.tx_half = pwdata[15:0];
            next_s.tbf     = 1'b1;
        end

        // Pin ownership
        next_s.sck_oe = s.en && master && !s.con1[spp_pkg::CON1_CLOCK_PIN_DISABLE];
        next_s.sdo_oe = s.en && !s.con1[spp_pkg::CON1_DATA_OUT_DISABLE]
                        && (master || s.state == spp_pkg::ST_SHIFT);
        next_s.ss_oe  = s.en && fs_out_mode;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s        <= '0;
            s.ss_out <= 1'b1;
            s.ss_q   <= 3'h7;
            s.ss_f   <= 1'b1;
            s.state  <= spp_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign prdata  = s.prdata;
    assign pready  = s.pready;
    assign pslverr = s.pslverr;
    assign sdo_o   = s.sdo;
    assign sdo_oe  = s.sdo_oe;
    assign sck_o   = s.sck;
    assign sck_oe  = s.sck_oe;
    assign ss_o    = s.ss_out;
    assign ss_oe   = s.ss_oe;

    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_tbf_write:
        assert property (buf_wr |=> s.tbf)
        else $error("transmit full not set after buffer write");
    chk_load_move:
        assert property (load && !buf_wr |=> !s.tbf && s.sr == $past(s.tx_half))
        else $error("transmit half not moved into shifter");
    chk_rbf_read:
        assert property (buf_rd && !word_done |=> !s.rbf)
        else $error("receive full not cleared by read");
    chk_rov_drop:
        assert property (word_done && s.rbf && !buf_rd |=> s.rov && $stable(s.rx_half))
        else $error("overflow not flagged or word not dropped");
    chk_byte_width:
        assert property (word_done && !s.rbf && !s.con1[spp_pkg::CON1_WORD_WIDTH_SELECT] |=> s.rbf && s.rx_half[15:8] == 8'h00)
        else $error("byte word carries upper bits");
    chk_port_off:
        assert property (!s.en |=> !s.sck_oe && !s.sdo_oe && !s.ss_oe)
        else $error("pins driven while port disabled");
    chk_sck_release:
        assert property (s.con1[spp_pkg::CON1_CLOCK_PIN_DISABLE] ##1 s.con1[spp_pkg::CON1_CLOCK_PIN_DISABLE] |-> !s.sck_oe)
        else $error("clock pin driven while disabled");
    chk_sdo_release:
        assert property (s.con1[spp_pkg::CON1_DATA_OUT_DISABLE] |=> !s.sdo_oe)
        else $error("data pin driven while disabled");
    chk_idle_level:
        assert property (run && s.state == spp_pkg::ST_IDLE && !load |=> s.sck == $past(s.con1[spp_pkg::CON1_CKP]))
        else $error("idle clock level wrong");
    chk_idle_halt:
        assert property (s.en && s.sidl && cpu_idle && s.state == spp_pkg::ST_SHIFT |=> $stable(s.sr))
        else $error("shifter moved while halted in idle");
    chk_frame_start:
        assert property (load && s.con2[spp_pkg::CON2_FRAMED_MODE_ENABLE] && !s.con2[spp_pkg::CON2_FSD] && s.con1[spp_pkg::CON1_MASTER_ENABLE]
                         |=> s.ss_out == $past(s.con2[spp_pkg::CON2_FRAME_SYNC_POLARITY]))
        else $error("frame sync not asserted at start");
endmodule

/* tb/spp_peer.sv */
// Far-side serial peripheral: a 16-bit exchange register, data changes and samples on the active-to-idle edge.
// Assumes the bench gives it the port's clock when driven, else the bench's own link clock.
`timescale 1ns/10ps
module spp_peer #(
    parameter logic [15:0] INIT = 16'h3C96
) (
    input  wire logic        sck,
    input  wire logic        cpol,
    input  wire logic        sdo,
    output logic             sdi,
    output logic      [15:0] word
);
    logic act;
    assign act = sck ^ cpol;
    assign sdi = word[15];
    initial word = INIT;
    // Samples on active-to-idle, shifts next bit out at the same moment
    always @(negedge act) begin
        word <= {word[14:0], sdo};
    end
endmodule

/* tb/test_spp_port.sv */
// Bench for the framed serial port: APB master tasks, one task per scenario.
// Assumes the watchdog bounds every APB wait and the peer is always selected.
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_spp_port;
    logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, cpu_idle;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        sdi_i, sdo_o, sdo_oe, sck_i, sck_o, sck_oe, ss_i, ss_o, ss_oe, err;
    logic [15:0] q, pw;
    int          num_errors, compares;
    spp_port i_spp_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_idle(cpu_idle), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sck_i(sck_i), .sck_o(sck_o),
        .sck_oe(sck_oe), .ss_i(ss_i), .ss_o(ss_o), .ss_oe(ss_oe));
    spp_peer i_spp_peer (.sck(sck_oe ? sck_o : sck_i), .cpol(1'b0), .sdo(sdo_o), .sdi(sdi_i), .word(pw));
    initial pclk = 1'b0;
    always #20 pclk = ~pclk;
    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= {16'h0000, d}; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[15:0];
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic poll(input int b);
        int n;
        n = 0;
        do apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); while (q[b] !== 1'b1 && ++n < 300);
        if (n == 300) begin
            num_errors++;
        end
    endtask
    task automatic t_regs;
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'h0000)
        apb(1'b0, 8'h10, 16'h0000); `CHK({err, q}, 17'h10000)
        apb(1'b1, spp_pkg::ADDR_CON1, 16'hFFFE); apb(1'b0, spp_pkg::ADDR_CON1, 16'h0000); `CHK(q, 16'h1FFE)
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h0000);
        apb(1'b1, spp_pkg::ADDR_CON2, 16'hFFFF); apb(1'b0, spp_pkg::ADDR_CON2, 16'h0000); `CHK(q, 16'hE002)
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h2043); apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'h2000)
        apb(1'b1, spp_pkg::ADDR_CON2, 16'h0000); apb(1'b1, spp_pkg::ADDR_STAT, 16'h0000);
    endtask
    task automatic t_word_overflow;
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h0423);
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h8000);
        apb(1'b1, spp_pkg::ADDR_BUF, 16'hA5C3);
        apb(1'b1, spp_pkg::ADDR_BUF, 16'h5A3C);
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'h8002)
        poll(0);
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'h8001)
        poll(6);
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'h8041)
        `CHK(pw, 16'h5A3C)
        apb(1'b0, spp_pkg::ADDR_BUF, 16'h0000); `CHK(q, 16'h3C96)
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h8000);
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'h8000)
    endtask
    task automatic t_byte_idle;
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h0023);
        apb(1'b1, spp_pkg::ADDR_STAT, 16'hA000);
        cpu_idle <= 1'b1;
        apb(1'b1, spp_pkg::ADDR_BUF, 16'h00B7);
        repeat (40) @(posedge pclk);
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'hA002)
        cpu_idle <= 1'b0;
        repeat (30) @(posedge pclk);
        cpu_idle <= 1'b1;
        repeat (20) @(posedge pclk);
        apb(1'b0, spp_pkg::ADDR_STAT, 16'h0000); `CHK(q, 16'hA000)
        cpu_idle <= 1'b0;
        poll(0);
        apb(1'b0, spp_pkg::ADDR_BUF, 16'h0000); `CHK(q, 16'h005A)
        `CHK(pw, 16'h3CB7)
    endtask
    task automatic t_frame;
        int n;
        n = 0;
        apb(1'b1, spp_pkg::ADDR_CON2, 16'h8000);
        apb(1'b1, spp_pkg::ADDR_BUF, 16'h0011);
        do @(posedge pclk); while (!(ss_o === 1'b0 && ss_oe === 1'b1) && ++n < 200);
        `CHK({ss_oe, ss_o}, 2'b10)
        repeat (14) @(posedge pclk);
        `CHK({ss_o, sck_o}, 2'b00)
        do @(posedge pclk); while (ss_o !== 1'b1 && ++n < 200);
        `CHK(sck_o, 1'b1)
        poll(0);
        apb(1'b0, spp_pkg::ADDR_BUF, 16'h0000); `CHK(q, 16'h003C)
        `CHK(pw, 16'hB711)
    endtask
    task automatic t_slave;
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h0000);
        apb(1'b1, spp_pkg::ADDR_CON2, 16'h0000);
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h0103);
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h8000);
        apb(1'b1, spp_pkg::ADDR_BUF, 16'h00C5);
        repeat (8) begin
            repeat (4) @(posedge pclk);
            sck_i <= 1'b1;
            repeat (4) @(posedge pclk);
            sck_i <= 1'b0;
        end
        poll(0);
        apb(1'b0, spp_pkg::ADDR_BUF, 16'h0000); `CHK(q, 16'h00B7)
        `CHK(pw, 16'h11C5)
    endtask
    task automatic t_pins;
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h0000);
        apb(1'b1, spp_pkg::ADDR_CON2, 16'h0000);
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h0063);
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h8000);
        repeat (4) @(posedge pclk);
        `CHK({sck_oe, sck_o, sdo_oe}, 3'b111)
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h1863);
        repeat (4) @(posedge pclk);
        `CHK({sck_oe, sdo_oe}, 2'b00)
        apb(1'b1, spp_pkg::ADDR_CON1, 16'h0063);
        apb(1'b1, spp_pkg::ADDR_STAT, 16'h0000);
        repeat (4) @(posedge pclk);
        `CHK({sck_oe, sdo_oe, ss_oe}, 3'b000)
    endtask
    task automatic report_and_stop;
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h00000000;
        cpu_idle = 1'b0; sck_i = 1'b0; ss_i = 1'b1; num_errors = 0; compares = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_word_overflow;
        t_byte_idle;
        t_frame;
        t_slave;
        t_pins;
        report_and_stop;
    end
    initial begin
        #(40 * 30000);
        num_errors++;
        report_and_stop;
    end
endmodule
